// ---- common/rsse_pkg.sv ----
/*
  Package for the rotate, subtract-with-borrow and decrement-skip
  execution block: register offsets, field positions, reset values,
  operation codes, sequencer states and the status flag carrier.
  Assumes a 32-bit APB register bus with a 12-bit byte address.
*/
package rsse_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000; // Operation issue
  localparam logic [11:0] OFS_ACC      = 12'h004; // Accumulator
  localparam logic [11:0] OFS_FLAGS    = 12'h008; // Status flags
  localparam logic [11:0] OFS_STATUS   = 12'h00c; // Sequencer state
  localparam logic [11:0] OFS_MEM_BASE = 12'h040; // Data memory window

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_OP_LSB      = 0;
  localparam int CTRL_OP_W        = 3;
  localparam int CTRL_ADDR_LSB    = 8;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_SKIP_BIT    = 1;
  localparam int STAT_CYC_LSB     = 8;
  localparam int FLAGS_W          = 6;
  localparam int DATA_W           = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;

  // ---------------------------------------------------------------
  // Operation codes and cycle counts
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_ROT_MEM = 3'h0; // rotate_right_carry_mem
  localparam logic [2:0] OP_ROT_ACC = 3'h1; // rotate_right_carry_to_acc
  localparam logic [2:0] OP_SUB_ACC = 3'h2; // subtract_borrow_to_acc
  localparam logic [2:0] OP_SUB_MEM = 3'h3; // subtract_borrow_to_mem
  localparam logic [2:0] OP_DEC_SKZ = 3'h4; // decrement_skip_zero
  localparam logic [7:0] CYC_PLAIN  = 8'h01;
  localparam logic [7:0] CYC_SKIP   = 8'h02;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SKIP} rsse_state_e;

  // Carry sits in bit 0 when the struct is viewed as a vector
  typedef struct packed {
    logic ext_carry_zero_flag;
    logic ext_sign_compare_flag;
    logic aux_carry_flag;
    logic zero_flag;
    logic overflow_flag;
    logic carry_flag;
  } rsse_flags_s;

endpackage

// ---- verilog/rsse_rotate_carry.sv ----
/*
  Right rotation of one byte through the carry flag.
  Assumes a purely combinational use inside the execution block.
*/
`timescale 1ns/10ps
`default_nettype none

module rsse_rotate_carry #(
  parameter int W = 8
) (
  // Operand
  input  wire logic [W-1:0] data_in,
  input  wire logic         carry_in,
  // Result
  output logic      [W-1:0] data_out,
  output logic              carry_out
);

  // ---------------------------------------------------------------
  // Rotation
  // ---------------------------------------------------------------

  // Old carry enters the top, bit 0 leaves into carry
  assign data_out  = {carry_in, data_in[W-1:1]};
  assign carry_out = data_in[0];

endmodule
`default_nettype wire

// ---- verilog/rsse_sub_borrow.sv ----
/*
  Byte subtraction with borrow: acc - mem - not carry, and all six
  status flags that it produces. Assumes combinational use.
*/
`timescale 1ns/10ps
`default_nettype none

module rsse_sub_borrow (
  // Operands
  input  wire logic [7:0]           acc_in,
  input  wire logic [7:0]           mem_in,
  input  wire rsse_pkg::rsse_flags_s flags_in,
  // Result
  output logic      [7:0]           diff_out,
  output rsse_pkg::rsse_flags_s     flags_out
);

  logic [8:0] full;
  logic [4:0] low;
  logic       borrow_in;

  // ---------------------------------------------------------------
  // Difference and flags
  // ---------------------------------------------------------------

  // Complement of carry is the incoming borrow
  assign borrow_in = ~flags_in.carry_flag;
  assign full      = {1'b0, acc_in} - {1'b0, mem_in} - {8'h00, borrow_in};
  assign low       = {1'b0, acc_in[3:0]} - {1'b0, mem_in[3:0]} - {4'h0, borrow_in};
  assign diff_out  = full[7:0];

  // Carry low on a negative result, high on zero or positive
  assign flags_out.carry_flag            = ~full[8];
  assign flags_out.aux_carry_flag        = ~low[4];
  assign flags_out.zero_flag             = (full[7:0] == 8'h00);
  assign flags_out.overflow_flag         = (acc_in[7] ^ mem_in[7]) & (full[7] ^ acc_in[7]);
  assign flags_out.ext_sign_compare_flag = flags_out.overflow_flag ^ full[7];
  assign flags_out.ext_carry_zero_flag   = (full[7:0] == 8'h00) & flags_in.zero_flag;

endmodule
`default_nettype wire

// ---- verilog/rsse_exec.sv ----
/*
  Execution block for right rotation through carry, subtraction with
  borrow and decrement-skip-if-zero, with its own accumulator, flags
  and byte data memory, all reached over APB.
  Register map, byte addresses:
    0x000 control: op code in 2:0, memory index from bit 8; a write
          starts the operation
    0x004 accumulator in 7:0
    0x008 status flags in 5:0, carry in bit 0
    0x00c sequencer state: busy, last op skipped, cycles of last op
    0x040 plus four times i: data memory byte i
  Every access has one wait state; a refused access answers with
  pslverr and changes nothing.
  Assumes a single system clock, a synchronous active high reset and
  an APB master that holds each request until pready is seen high.
*/
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none

// Contract
// RL1: Rotate to memory shifts the byte right, old carry into bit 7, old bit 0 into carry, writes back.
// RL2: Rotate to accumulator puts the rotated byte in the accumulator and carry takes old bit 0.
// RL3: Rotate to accumulator leaves the addressed memory byte as it was.
// RL4: Subtract with borrow gives accumulator minus memory minus inverted carry into the accumulator.
// RL5: After either subtract form carry is 0 for a negative difference and 1 otherwise.
// RL6: The memory form of subtract writes the difference to the addressed byte, not the accumulator.
// RL7: Both subtract forms update overflow, zero, aux carry, carry and the two extended flags.
// RL8: Decrement-skip subtracts 1 from the byte and skips the next instruction when it reaches 0.
// RL9: A taken skip inserts a dummy cycle so the instruction lasts two instruction cycles.
// RL10: A nonzero result continues with the following instruction without a skip.
// RL11: Rotations change only carry; zero, overflow and the rest keep their values.
module rsse_exec #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Sequencer side
  output logic             exec_busy_out,
  output logic             skip_cycle_out,
  output logic      [7:0]  accumulator_out,
  output logic             carry_flag_out
);

  // ---------------------------------------------------------------
  // Local types and constants
  // ---------------------------------------------------------------
  // Index width and end of the memory window
  localparam int          ADDR_W  = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [11:0] MEM_END = 12'(rsse_pkg::OFS_MEM_BASE + 4 * DEPTH);

  typedef struct packed {
    // Sequencer and the operation in hand
    rsse_pkg::rsse_state_e       st;
    logic [2:0]                  op;
    logic [ADDR_W-1:0]           addr;
    // Datapath state
    logic [7:0]                  acc;
    rsse_pkg::rsse_flags_s       flags;
    // Record of the last operation
    logic                        last_skip;
    logic [7:0]                  last_cycles;
    // Bus answer
    logic                        ack;
    logic                        slverr;
    logic [31:0]                 rdata;
    // Data memory, one byte per word
    logic [DEPTH-1:0][7:0]       mem;
  } rsse_core_s;

  // Registered state and its next value
  rsse_core_s            cur;
  rsse_core_s            next_cur;

  // Operand and unit results
  logic [7:0]            mem_byte;
  logic [7:0]            rot_byte;
  logic                  rot_carry;
  logic [7:0]            sub_byte;
  rsse_pkg::rsse_flags_s sub_flags;
  logic [7:0]            dec_byte;

  // Bus decode and handshake
  logic                  hit_ctrl;
  logic                  hit_acc;
  logic                  hit_flags;
  logic                  hit_status;
  logic                  hit_mem;
  logic [ADDR_W-1:0]     bus_idx;
  logic                  busy;
  logic                  op_legal;
  logic                  first_phase;
  logic                  commit_wr;
  logic [31:0]           read_word;
  logic                  access_err;

  // ---------------------------------------------------------------
  // Arithmetic units
  // ---------------------------------------------------------------

  // Byte under the current operation
  assign mem_byte = cur.mem[cur.addr];

  // Decremented byte for the skip test
  assign dec_byte = mem_byte - 8'h01;

  // Rotation through carry
  rsse_rotate_carry #(
    .W         (rsse_pkg::DATA_W)
  ) u_rotate (
    .data_in   (mem_byte),
    .carry_in  (cur.flags.carry_flag),
    .data_out  (rot_byte),
    .carry_out (rot_carry)
  );

  // Subtraction with borrow and its flags
  rsse_sub_borrow u_sub (
    .acc_in    (cur.acc),
    .mem_in    (mem_byte),
    .flags_in  (cur.flags),
    .diff_out  (sub_byte),
    .flags_out (sub_flags)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------

  // Register and memory window hits
  assign hit_ctrl   = (paddr_in == rsse_pkg::OFS_CTRL);
  assign hit_acc    = (paddr_in == rsse_pkg::OFS_ACC);
  assign hit_flags  = (paddr_in == rsse_pkg::OFS_FLAGS);
  assign hit_status = (paddr_in == rsse_pkg::OFS_STATUS);
  assign hit_mem    = (paddr_in >= rsse_pkg::OFS_MEM_BASE) && (paddr_in < MEM_END)
                      && (paddr_in[1:0] == 2'b00);

  // Word index into the memory window
  assign bus_idx    = paddr_in[ADDR_W+1:2];

  // Any state but idle counts as busy
  assign busy     = (cur.st != rsse_pkg::ST_IDLE);

  // Codes above the last defined one are refused
  assign op_legal = (pwdata_in[rsse_pkg::CTRL_OP_LSB +: rsse_pkg::CTRL_OP_W]
                     <= rsse_pkg::OP_DEC_SKZ);

  // First access cycle samples; the next one completes
  assign first_phase = psel_in && penable_in && !cur.ack;
  assign commit_wr   = psel_in && penable_in && cur.ack && pwrite_in
                       && !cur.slverr && pstrb_in[0];

  // Read data for the addressed word
  always_comb begin
    read_word = 32'h0000_0000;
    if (hit_ctrl) begin
      read_word[rsse_pkg::CTRL_OP_LSB +: rsse_pkg::CTRL_OP_W] = cur.op;
      read_word[rsse_pkg::CTRL_ADDR_LSB +: ADDR_W]            = cur.addr;
    end else if (hit_acc) begin
      read_word[7:0] = cur.acc;
    end else if (hit_flags) begin
      read_word[rsse_pkg::FLAGS_W-1:0] = cur.flags;
    end else if (hit_status) begin
      read_word[rsse_pkg::STAT_BUSY_BIT]    = busy;
      read_word[rsse_pkg::STAT_SKIP_BIT]    = cur.last_skip;
      read_word[rsse_pkg::STAT_CYC_LSB +: 8] = cur.last_cycles;
    end else if (hit_mem) begin
      read_word[7:0] = cur.mem[bus_idx];
    end
  end

  // Unmapped, bad opcode, or a write that would race execution
  always_comb begin
    access_err = 1'b0;
    if (!(hit_ctrl || hit_acc || hit_flags || hit_status || hit_mem)) begin
      // Unmapped or misaligned
      access_err = 1'b1;
    end else if (pwrite_in && busy && !hit_status) begin
      // Only the state word may be written while busy
      access_err = 1'b1;
    end else if (pwrite_in && hit_ctrl && !op_legal) begin
      // Undefined op code
      access_err = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Bus handshake, register writes and the execution sequencer
  always_comb begin
    next_cur = cur;

    // APB: one wait state, read data captured in flops
    if (first_phase) begin
      // Latch the answer for the second access cycle
      next_cur.ack    = 1'b1;
      next_cur.rdata  = read_word;
      next_cur.slverr = access_err;
    end else begin
      // Answer stands for one cycle only
      next_cur.ack    = 1'b0;
      next_cur.slverr = 1'b0;
    end

    // Register writes land on the completing edge
    if (commit_wr) begin
      if (hit_ctrl) begin
        // Control write launches the operation
        next_cur.op   = pwdata_in[rsse_pkg::CTRL_OP_LSB +: rsse_pkg::CTRL_OP_W];
        next_cur.addr = pwdata_in[rsse_pkg::CTRL_ADDR_LSB +: ADDR_W];
        next_cur.st   = rsse_pkg::ST_EXEC;
      end else if (hit_acc) begin
        // Software preset of the accumulator
        next_cur.acc = pwdata_in[7:0];
      end else if (hit_flags) begin
        // Software may preset any flag
        next_cur.flags = rsse_pkg::rsse_flags_s'(pwdata_in[rsse_pkg::FLAGS_W-1:0]);
      end else if (hit_mem) begin
        // Byte lane 0 carries the data
        next_cur.mem[bus_idx] = pwdata_in[7:0];
      end
    end

    // Execution sequencer: one cycle, or two on a skip
    unique case (cur.st)
      rsse_pkg::ST_IDLE: begin
        // Wait for a control write
      end

      rsse_pkg::ST_EXEC: begin
        next_cur.st          = rsse_pkg::ST_IDLE;
        next_cur.last_skip   = 1'b0;
        next_cur.last_cycles = rsse_pkg::CYC_PLAIN;
        unique case (cur.op)
          rsse_pkg::OP_ROT_MEM: begin
            // RL1: rotate back to memory
            next_cur.mem[cur.addr] = rot_byte;
            // RL11: only carry changes
            next_cur.flags.carry_flag = rot_carry;
          end
          rsse_pkg::OP_ROT_ACC: begin
            // RL2: rotate into accumulator
            next_cur.acc = rot_byte;
            next_cur.flags.carry_flag = rot_carry;
            // RL3: memory byte untouched
            next_cur.mem[cur.addr] = mem_byte;
          end
          rsse_pkg::OP_SUB_ACC: begin
            // RL4: difference to accumulator
            next_cur.acc = sub_byte;
            // RL5: carry from sign of result
            // RL7: all six flags updated
            next_cur.flags = sub_flags;
          end
          rsse_pkg::OP_SUB_MEM: begin
            // RL6: difference to memory
            next_cur.mem[cur.addr] = sub_byte;
            // RL7: all six flags updated
            next_cur.flags = sub_flags;
          end
          rsse_pkg::OP_DEC_SKZ: begin
            // RL8: decrement byte in place
            next_cur.mem[cur.addr] = dec_byte;
            if (dec_byte == 8'h00) begin
              // RL9: dummy cycle on skip
              next_cur.st          = rsse_pkg::ST_SKIP;
              next_cur.last_skip   = 1'b1;
              next_cur.last_cycles = rsse_pkg::CYC_SKIP;
            end
            // RL10: nonzero falls through to idle
          end
          default: begin
            // Refused codes never get here
            next_cur.last_cycles = 8'h00;
          end
        endcase
      end

      rsse_pkg::ST_SKIP: begin
        // RL9: second cycle ends the instruction
        next_cur.st = rsse_pkg::ST_IDLE;
      end

      default: begin
        // Unused state code returns to idle
        next_cur.st = rsse_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------

  // Synchronous reset to constants
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cur.st          <= rsse_pkg::ST_IDLE;
      cur.op          <= 3'h0;
      cur.addr        <= '0;
      cur.acc         <= rsse_pkg::ACC_RST;
      cur.flags       <= rsse_pkg::rsse_flags_s'(rsse_pkg::FLAGS_RST);
      cur.last_skip   <= 1'b0;
      cur.last_cycles <= 8'h00;
      cur.ack         <= 1'b0;
      cur.slverr      <= 1'b0;
      cur.rdata       <= 32'h0000_0000;
      cur.mem         <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Bus answer, standing for one cycle
  assign prdata_out      = cur.rdata;
  assign pready_out      = cur.ack;
  assign pslverr_out     = cur.ack & cur.slverr;

  // Sequencer view
  assign exec_busy_out   = busy;
  assign skip_cycle_out  = (cur.st == rsse_pkg::ST_SKIP);
  assign accumulator_out = cur.acc;
  assign carry_flag_out  = cur.flags.carry_flag;

endmodule
`default_nettype wire

// ---- tb/rsse_exec_assertions.sv ----
/*
  Concurrent checks on the ports of the execution block.
  Assumes binding to rsse_exec with one clock and a sync reset.
*/
`timescale 1ns/10ps
`default_nettype none

module rsse_exec_assertions (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  // APB
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic        pready_out,
  input  wire logic        pslverr_out,
  // Sequencer side
  input  wire logic        exec_busy_out,
  input  wire logic        skip_cycle_out,
  input  wire logic [7:0]  accumulator_out,
  input  wire logic        carry_flag_out
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  // Completed write of any kind
  logic wr_done;
  assign wr_done = psel_in && penable_in && pready_out && pwrite_in;

  a_ready_one_wait: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
    else $error("pready not in second access cycle");
  a_error_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_busy_from_ctrl: assert property ($rose(exec_busy_out) |->
    $past(wr_done && !pslverr_out && paddr_in == rsse_pkg::OFS_CTRL))
    else $error("busy without a control write");
  a_busy_bounded: assert property (exec_busy_out |-> ##[1:2] !exec_busy_out)
    else $error("operation runs too long");
  a_skip_in_exec: assert property (skip_cycle_out |-> exec_busy_out && $past(exec_busy_out))
    else $error("skip cycle outside an operation");
  a_skip_single: assert property (skip_cycle_out |=> !skip_cycle_out && !exec_busy_out)
    else $error("skip cycle not a single closing cycle");
  a_acc_cause: assert property ($changed(accumulator_out) |->
    $past(exec_busy_out) || $past(wr_done))
    else $error("accumulator changed without cause");
  a_carry_cause: assert property ($changed(carry_flag_out) |->
    $past(exec_busy_out) || $past(wr_done))
    else $error("carry changed without cause");

  // Main scenarios reached
  c_skip: cover property (skip_cycle_out);
  c_refused: cover property (pslverr_out);
  c_plain_op: cover property ($fell(exec_busy_out) && !$past(skip_cycle_out));
endmodule
`default_nettype wire

// ---- tb/rsse_apb_master.sv ----
/*
  Sequencer model: an APB master that issues one transfer at a time.
  Assumes the bench watchdog ends a wait that never sees pready.
*/
`timescale 1ns/10ps
`default_nettype none

module rsse_apb_master (
  // Clock
  input  wire logic        clk_sys_in,
  // Answer
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  // Request
  output var  logic        psel_out,
  output var  logic        penable_out,
  output var  logic        pwrite_out,
  output var  logic [11:0] paddr_out,
  output var  logic [31:0] pwdata_out,
  output var  logic [3:0]  pstrb_out
);
  // Idle bus at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
    pstrb_out = 4'hf;
  end

  // One transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_sys_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out <= ~d; // Released data no longer shows the last value
  endtask
endmodule
`default_nettype wire

// ---- tb/rsse_exec_test.sv ----
/*
  Self-checking bench for the execution block over APB.
  Assumes the sequencer model and the checker from this folder.
*/
`timescale 1ns/10ps
`default_nettype none

module rsse_exec_test;
  logic        clk_sys_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, busy, skip, carry;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [7:0]  acc;
  logic        e;
  int          errors = 0;
  int          checks_done = 0;
  int          skips = 0;

  // ---------------------------------------------------------------
  // Clock, model and design
  // ---------------------------------------------------------------
  initial forever #12.5 clk_sys_in = ~clk_sys_in;

  rsse_apb_master rsse_apb_master_i (.clk_sys_in(clk_sys_in), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));

  rsse_exec #(.DEPTH(16)) rsse_exec_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .exec_busy_out(busy), .skip_cycle_out(skip),
    .accumulator_out(acc), .carry_flag_out(carry));

  // Count inserted dummy cycles
  always @(posedge clk_sys_in) if (skip === 1'b1) skips++;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    rsse_apb_master_i.xfer(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    rsse_apb_master_i.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic op(input logic [2:0] code, input logic [3:0] i);
    wr(rsse_pkg::OFS_CTRL, {20'h0, i, 5'h0, code});
  endtask

  task automatic refused(input logic w, input logic [11:0] a, input logic [31:0] d);
    rsse_apb_master_i.xfer(w, a, d, r, e);
    chk({31'h0, e}, 32'h1);
  endtask

  function automatic logic [11:0] ma(input logic [3:0] i);
    return rsse_pkg::OFS_MEM_BASE + {6'h0, i, 2'b00};
  endfunction

  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rd(rsse_pkg::OFS_ACC, 32'h0);
    rd(rsse_pkg::OFS_FLAGS, 32'h0);
    rd(rsse_pkg::OFS_STATUS, 32'h0);
    wr(ma(4'h3), 32'h81);
    wr(rsse_pkg::OFS_FLAGS, 32'h05);
    op(rsse_pkg::OP_ROT_MEM, 4'h3);
    rd(ma(4'h3), 32'hc0);
    rd(rsse_pkg::OFS_FLAGS, 32'h05);
    op(rsse_pkg::OP_ROT_ACC, 4'h3);
    rd(ma(4'h3), 32'hc0);
    chk({24'h0, acc}, 32'he0);
    chk({31'h0, carry}, 32'h0);
    rd(rsse_pkg::OFS_FLAGS, 32'h04);
    wr(rsse_pkg::OFS_ACC, 32'h10);
    wr(ma(4'h5), 32'h20);
    wr(rsse_pkg::OFS_FLAGS, 32'h01);
    op(rsse_pkg::OP_SUB_ACC, 4'h5);
    rd(rsse_pkg::OFS_ACC, 32'hf0);
    rd(rsse_pkg::OFS_FLAGS, 32'h18);
    op(rsse_pkg::OP_SUB_MEM, 4'h5);
    rd(ma(4'h5), 32'hcf);
    rd(rsse_pkg::OFS_ACC, 32'hf0);
    rd(rsse_pkg::OFS_FLAGS, 32'h11);
    wr(ma(4'h7), 32'h02);
    op(rsse_pkg::OP_DEC_SKZ, 4'h7);
    rd(ma(4'h7), 32'h01);
    rd(rsse_pkg::OFS_STATUS, 32'h0100);
    chk(skips, 32'h0);
    op(rsse_pkg::OP_DEC_SKZ, 4'h7);
    rd(ma(4'h7), 32'h00);
    rd(rsse_pkg::OFS_STATUS, 32'h0202);
    chk(skips, 32'h1);
    rd(rsse_pkg::OFS_FLAGS, 32'h11);
    refused(1'b0, 12'h010, 32'h0);
    refused(1'b0, 12'h041, 32'h0);
    refused(1'b1, rsse_pkg::OFS_CTRL, 32'h5);
    tally_and_finish();
  end

  // Cut a hang short
  initial begin
    #(25 * 4000);
    errors++;
    tally_and_finish();
  end
endmodule

bind rsse_exec rsse_exec_assertions rsse_exec_assertions_i (.clk_sys_in(clk_sys_in),
  .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .exec_busy_out(exec_busy_out), .skip_cycle_out(skip_cycle_out),
  .accumulator_out(accumulator_out), .carry_flag_out(carry_flag_out));
`default_nettype wire
